// File: verification/die_link_pair_asserts.sv
// Wire checks on the die link between the two design ends
`timescale 1ns/10ps
module die_link_pair_asserts
  import link_pkg::*;
#(
  parameter int HALF_COUNT = LINK_HALF_PERIOD
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clock,
  input wire logic [7:0] ini_dat,
  input wire logic ini_dat_oe,
  input wire logic [7:0] tgt_dat,
  input wire logic tgt_dat_oe,
  input wire logic [7:0] dat,
  input wire logic ack,
  input wire logic err,
  input wire logic [1:0] par,
  input wire logic target_irq_pin
);
  // ------------------------------------------------------------
  // Link clock phase length
  // ------------------------------------------------------------
  logic [7:0] phase_q;
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= 8'h00;
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= link_clock;
      if (link_clock != prev_q)
        phase_q <= 8'h00;
      else if (phase_q != 8'hff)
        phase_q <= phase_q + 8'h01;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_CLK_HIGH: assert property (
    $fell(link_clock) |-> phase_q == HALF_COUNT - 1)
    else $error("Link clock high phase has wrong length");
  AST_CLK_LOW: assert property (
    $rose(link_clock) |-> phase_q >= HALF_COUNT - 1)
    else $error("Link clock low phase too short");
  // Both ends move every line but the interrupt pin only in the low phase, so rises sample clean data
  AST_INI_DRIVE_LOW: assert property (
    ($rose(ini_dat_oe) || (ini_dat_oe && $changed(ini_dat))) |-> !link_clock)
    else $error("Initiator changed data while link clock high");
  AST_TGT_DRIVE_LOW: assert property (
    ($changed(ack) || $changed(par)) |-> !link_clock)
    else $error("Target changed ack or parity while link clock high");
  AST_ACK_RELEASED: assert property (
    $rose(ack) |-> !ini_dat_oe)
    else $error("Acknowledge while initiator still drives data");
  AST_ACK_PATTERN: assert property (
    $rose(ack) |-> tgt_dat_oe && tgt_dat == ACK_PATTERN)
    else $error("Acknowledge without all data lines high");
  AST_ERR_IN_ACK: assert property (
    err |-> ack)
    else $error("Error line high outside acknowledge");
  AST_READ_PARITY: assert property (
    $rose(link_clock) && tgt_dat_oe && !ini_dat_oe && !ack
      |-> par == {^dat[7:4], ^dat[3:0]})
    else $error("Read data sent with wrong parity");

  cover property ($rose(ack));
  cover property ($rose(err));
  cover property ($rose(target_irq_pin));
endmodule // die_link_pair_asserts

// File: verification/tb_die_link_initiator_ctrl_status.sv
// Testbench for the die link initiator and target pair
`timescale 1ns/10ps
`define CHK(n, e, g) \
  compares++; \
  if ((g) !== (e)) \
  begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
    err_count++; \
  end
module tb_die_link_initiator_ctrl_status
  import link_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic psel_a = 1'b0, psel_b = 1'b0, sel_b = 1'b0, special_mode = 1'b0;
  logic [7:0] paddr = 8'h00, rsp_rdata = 8'h00, fdat = 8'hff, ra, rdv;
  logic [31:0] pwdata = 32'h0, prdata_a, prdata_b;
  logic rsp_ready = 1'b0, rsp_err = 1'b0, irq_raise = 1'b0;
  logic pready_a, pready_b, pslverr_a, pslverr_b, irq_a, irq_b;
  logic req_valid, req_write;
  logic [7:0] req_addr, req_wdata;
  logic [1:0] fpar = 2'b11;
  logic [3:0] lim;
  logic [64:0] apb_q[$], e;
  logic [33:0] req_q[$], r;
  int err_count = 0, compares = 0;
  wire pready_m = psel_b ? pready_b : pready_a;
  wire pslverr_m = psel_b ? pslverr_b : pslverr_a;
  wire [31:0] prdata_m = psel_b ? prdata_b : prdata_a;

  always #20 pclk = ~pclk;

  link_if u_link_if ();
  link_if u_link_if_faulty ();
  die_link_initiator #(.HALF_COUNT(LINK_HALF_PERIOD)) u_die_link_initiator (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_a),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_a),
    .pready(pready_a), .pslverr(pslverr_a), .irq(irq_a),
    .special_mode(special_mode), .link(u_link_if));
  die_link_initiator #(.HALF_COUNT(LINK_HALF_PERIOD))
    u_die_link_initiator_faulty (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_b),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_b),
    .pready(pready_b), .pslverr(pslverr_b), .irq(irq_b),
    .special_mode(1'b0), .link(u_link_if_faulty));
  die_link_target u_die_link_target (
    .pclk(pclk), .presetn(presetn), .link(u_link_if),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_ready(rsp_ready), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .irq_raise(irq_raise));
  die_link_pair_asserts #(.HALF_COUNT(LINK_HALF_PERIOD))
    u_die_link_pair_asserts (
    .pclk(pclk), .presetn(presetn), .link_clock(u_link_if.link_clock),
    .ini_dat(u_link_if.ini_dat), .ini_dat_oe(u_link_if.ini_dat_oe),
    .tgt_dat(u_link_if.tgt_dat), .tgt_dat_oe(u_link_if.tgt_dat_oe),
    .dat(u_link_if.dat), .ack(u_link_if.ack), .err(u_link_if.err),
    .par(u_link_if.par), .target_irq_pin(u_link_if.target_irq_pin));

  // ------------------------------------------------------------
  // Faulty far end
  // ------------------------------------------------------------
  // Holds ack and data forever, so each frame meets the chosen fault
  assign u_link_if_faulty.tgt_dat = fdat;
  assign u_link_if_faulty.tgt_dat_oe = 1'b1;
  assign u_link_if_faulty.ack = 1'b1;
  assign u_link_if_faulty.err = 1'b0;
  assign u_link_if_faulty.par = fpar;
  assign u_link_if_faulty.target_irq_pin = 1'b0;

  always @(posedge pclk)
  begin
    if ((psel_a || psel_b) && penable && pready_m)
    begin
      e = apb_q.size() ? apb_q.pop_front() : 'x;
      `CHK("apb", {e[64], e[31:0]}, {pslverr_m, prdata_m & e[63:32]});
    end
    if (req_valid)
    begin
      r = req_q.size() ? req_q.pop_front() : 'x;
      `CHK("req", r[16:0], {req_write, req_wdata, req_addr} & r[33:17]);
    end
  end

  task automatic final_report(input logic timed_out);
    if (timed_out)
      err_count++;
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, m, x, input logic se);
    int n;
    apb_q.push_back({se, m, x});
    psel_a <= !sel_b;
    psel_b <= sel_b;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready_m && n < 100);
    psel_a <= 1'b0;
    psel_b <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 100)
      final_report(1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'b0, a, 32'h0, m, x, 1'b0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while ((sel_b ? irq_b : irq_a) !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
      final_report(1'b1);
  endtask

  task automatic req(input logic w, input logic [7:0] a, d);
    if (!sel_b)
      req_q.push_back({w ? 17'h1ffff : 17'h100ff, w, d, a});
    wr(OFS_REQUEST, {15'h0, w, d, a});
    rd(OFS_PIN_BUSY, 32'h40, 32'h40);
    wait_irq();
    wr(OFS_IRQ_STATUS, 32'h7);
  endtask

  initial
  begin
    void'($urandom(28));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CONTROL_ONE, 32'hff, 32'h0);
    rd(OFS_ERROR_STATUS, 32'hff, 32'h0);
    rd(OFS_PIN_BUSY, 32'hff, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    wr(OFS_CONTROL_ONE, 32'h03);
    rd(OFS_CONTROL_ONE, 32'hff, 32'h03);
    wr(OFS_CONTROL_ZERO, 32'h80);
    wr(OFS_CONTROL_ONE, 32'h0f);
    rd(OFS_CONTROL_ONE, 32'h0f, 32'h03);
    lim = 4'($urandom_range(15, 1));
    special_mode <= 1'b1;
    wr(OFS_CONTROL_ONE, {28'h0, lim});
    rd(OFS_CONTROL_ONE, 32'h0f, {28'h0, lim});
    special_mode <= 1'b0;
    wr(OFS_IRQ_MASK, 32'h3);
    rsp_ready <= 1'b1;
    ra = 8'($urandom_range(254, 0));
    rdv = 8'($urandom);
    req(1'b1, ra, rdv);
    rd(OFS_PIN_BUSY, 32'h40, 32'h0);
    rd(OFS_ERROR_STATUS, 32'hff, 32'h0);
    rsp_rdata <= rdv;
    req(1'b0, ra, 8'h00);
    rd(OFS_REQUEST, 32'hff, {24'h0, rdv});
    rd(OFS_ERROR_STATUS, 32'hff, 32'h0);
    rsp_err <= 1'b1;
    req(1'b1, ra, rdv);
    rsp_err <= 1'b0;
    rd(OFS_ERROR_STATUS, 32'hff, 32'h88);
    wr(OFS_REQUEST, 32'h10000);
    // No frame may follow, so the target must stay silent meanwhile
    repeat (128) @(posedge pclk);
    rd(OFS_ERROR_STATUS, 32'hff, 32'ha8);
    wr(OFS_ERROR_STATUS, 32'h7f);
    rd(OFS_ERROR_STATUS, 32'hff, 32'ha8);
    wr(OFS_ERROR_STATUS, 32'h80);
    rd(OFS_ERROR_STATUS, 32'hff, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CONTROL_ONE, {28'h0, lim});
    irq_raise <= 1'b1;
    @(posedge pclk);
    irq_raise <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(OFS_PIN_BUSY, 32'h80, 32'h80);
    rd(OFS_IRQ_STATUS, 32'h4, 32'h0);
    `CHK("irq", 1'b0, irq_a);
    wr(OFS_CONTROL_ONE, {24'h0, 4'h8, lim});
    wait_irq();
    rd(OFS_IRQ_STATUS, 32'h4, 32'h4);
    wr(OFS_IRQ_STATUS, 32'h4);
    rd(OFS_PIN_BUSY, 32'h80, 32'h80);
    wr(OFS_IRQ_MASK, 32'h2);
    req(1'b1, IRQ_ACK_ADDR, 8'h00);
    repeat (20) @(posedge pclk);
    rd(OFS_PIN_BUSY, 32'h80, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_MASK, 32'h3);
    rsp_ready <= 1'b0;
    req(1'b1, ra, rdv);
    rd(OFS_ERROR_STATUS, 32'hff, 32'h90);
    rd(OFS_PIN_BUSY, 32'h40, 32'h0);
    sel_b = 1'b1;
    wr(OFS_CONTROL_ZERO, 32'h80);
    wr(OFS_IRQ_MASK, 32'h1);
    req(1'b0, 8'h10, 8'h00);
    rd(OFS_ERROR_STATUS, 32'hff, 32'h87);
    wr(OFS_ERROR_STATUS, 32'h80);
    fdat <= 8'h7f;
    req(1'b1, 8'h10, 8'h00);
    rd(OFS_ERROR_STATUS, 32'hc0, 32'hc0);
    final_report(1'b0);
  end
endmodule // tb_die_link_initiator_ctrl_status

// File: verilog/die_link_initiator.sv
// Initiator end of the die link with its APB register bank
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
// Operation
// [RQ1] Interrupt enable gates the target interrupt
// [RQ2] Wait limit counts link clocks, then timeout
// [RQ3] Limit zero: acknowledge immediately, no waits
// [RQ4] Nonzero limit: timeout only past limit waits
// [RQ5] Limit write-once normally, free in special mode
// [RQ6] After enable, write-once bits ignore writes
// [RQ7] Summary flag set by any error, unmaskable
// [RQ8] Write one clears summary, zero ignored
// [RQ9] Acknowledge data not all high: wire error
// [RQ10] Pending error cancels request, sends idle
// [RQ11] Timeout sets wait expired flag
// [RQ12] Target error in acknowledge sets flag
// [RQ13] Parity error flag plus received parity bits
// [RQ14] Specific flags cleared only with summary
// [RQ15] Target interrupt level reflects pin only
// [RQ16] Busy bit high while transaction runs
// [RQ17] Software writes zero to reserved bits
// [RQ18] Target drives interrupt high, pulled down
// [RQ19] Wait count restarts after last transfer
module die_link_initiator
  import link_pkg::*;
#(
  parameter int HALF_COUNT = LINK_HALF_PERIOD
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic special_mode,
  link_if.initiator link
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_WAIT, ST_RDATA
  } phase_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_enable;
    logic target_irq_enable;
    logic [3:0] ack_wait_limit;
    logic [7:0] err_stat;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic pend;
    logic pend_write;
    logic [7:0] pend_addr;
    logic [7:0] pend_wdata;
    logic [7:0] rdata;
    phase_type phase;
    logic [3:0] waits;
    logic [7:0] div;
    logic link_clock;
    logic [7:0] dat;
    logic dat_oe;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [12:0] sync_level;
  logic [7:0] rx_dat;
  logic rx_ack;
  logic rx_err;
  logic [1:0] rx_par;
  logic rx_irq;
  logic rise;
  logic fall;
  logic setup;
  logic wr;
  logic [7:0] err_set;
  logic done;
  logic busy;

  pin_sync #(.WIDTH(13)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({link.target_irq_pin, link.par, link.err, link.ack, link.dat}),
    .level(sync_level)
  );

  assign {rx_irq, rx_par, rx_err, rx_ack, rx_dat} = sync_level;

  always_comb
  begin
    s_d = s_q;
    rise = 1'b0;
    fall = 1'b0;
    err_set = 8'h00;
    done = 1'b0;
    busy = (s_q.phase != ST_IDLE) | s_q.pend; // [RQ16]
    setup = psel & ~penable & ~s_q.pready;
    wr = psel & penable & s_q.pready & pwrite;
    // -------------------------------------------------------------
    // Link clock divider
    // -------------------------------------------------------------
    if (s_q.link_enable)
    begin
      if (s_q.div == 8'(HALF_COUNT - 1))
      begin
        s_d.div = 8'h00;
        s_d.link_clock = ~s_q.link_clock;
        rise = ~s_q.link_clock;
        fall = s_q.link_clock;
      end
      else
        s_d.div = s_q.div + 8'h01;
    end
    // -------------------------------------------------------------
    // Link sequencing: drive on fall, sample on rise
    // -------------------------------------------------------------
    if (fall)
      case (s_q.phase)
        ST_IDLE:
        begin
          s_d.dat = CMD_IDLE;
          s_d.dat_oe = 1'b1;
          if (s_q.pend)
          begin
            s_d.pend = 1'b0;
            if (s_q.err_stat[ERROR_SUMMARY_BIT])
              err_set[CANCEL_BIT] = 1'b1; // [RQ10]
            else
            begin
              s_d.dat = s_q.pend_write ? CMD_WRITE : CMD_READ;
              s_d.phase = ST_CMD;
            end
          end
        end
        ST_CMD:
        begin
          s_d.dat = s_q.pend_addr;
          s_d.phase = ST_ADDR;
        end
        ST_ADDR:
          if (s_q.pend_write)
          begin
            s_d.dat = s_q.pend_wdata;
            s_d.phase = ST_WDATA;
          end
          else
          begin
            s_d.dat_oe = 1'b0;
            s_d.waits = 4'h0; // [RQ19]
            s_d.phase = ST_WAIT;
          end
        ST_WDATA:
        begin
          s_d.dat_oe = 1'b0;
          s_d.waits = 4'h0; // [RQ19]
          s_d.phase = ST_WAIT;
        end
        default:
          s_d.phase = s_q.phase;
      endcase
    if (rise)
      case (s_q.phase)
        ST_WAIT:
          if (rx_ack)
          begin
            err_set[ACK_WIRE_BIT] = (rx_dat != ACK_PATTERN); // [RQ9]
            err_set[TARGET_ERROR_BIT] = rx_err; // [RQ12]
            s_d.phase = s_q.pend_write ? ST_IDLE : ST_RDATA;
            done = s_q.pend_write;
          end
          else if (s_q.waits == s_q.ack_wait_limit) // [RQ2] [RQ3] [RQ4]
          begin
            err_set[WAIT_EXPIRED_BIT] = 1'b1; // [RQ11]
            s_d.phase = ST_IDLE;
            done = 1'b1;
          end
          else
            s_d.waits = s_q.waits + 4'h1;
        ST_RDATA:
        begin
          s_d.rdata = rx_dat;
          if (rx_par != {^rx_dat[7:4], ^rx_dat[3:0]})
            err_set[PARITY_ERROR_BIT] = 1'b1;
          s_d.phase = ST_IDLE;
          done = 1'b1;
        end
        default:
          s_d.phase = s_q.phase;
      endcase
    if (!s_q.link_enable)
    begin
      s_d.phase = ST_IDLE;
      s_d.dat_oe = 1'b0;
    end
    // -------------------------------------------------------------
    // APB slave: answer one cycle after setup
    // -------------------------------------------------------------
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup)
    begin
      s_d.prdata = 32'h0000_0000;
      if (paddr == OFS_CONTROL_ZERO)
        s_d.prdata[LINK_ENABLE_BIT] = s_q.link_enable;
      else if (paddr == OFS_CONTROL_ONE)
        s_d.prdata[7:0] = {s_q.target_irq_enable, 3'h0, s_q.ack_wait_limit};
      else if (paddr == OFS_ERROR_STATUS)
        s_d.prdata[7:0] = s_q.err_stat;
      else if (paddr == OFS_PIN_BUSY)
        s_d.prdata[7:0] = {rx_irq, busy, 6'h00}; // [RQ15] [RQ16]
      else if (paddr == OFS_REQUEST)
        s_d.prdata[7:0] = s_q.rdata;
      else if (paddr == OFS_IRQ_STATUS)
        s_d.prdata[2:0] = s_q.irq_stat;
      else if (paddr == OFS_IRQ_MASK)
        s_d.prdata[2:0] = s_q.irq_mask;
      else
        s_d.pslverr = 1'b1;
    end
    if (wr)
    begin
      // Write-once fields lock once the link is enabled, unless special_mode is high
      if (paddr == OFS_CONTROL_ZERO && (!s_q.link_enable || special_mode))
        s_d.link_enable = pwdata[LINK_ENABLE_BIT]; // [RQ6]
      else if (paddr == OFS_CONTROL_ONE)
      begin
        s_d.target_irq_enable = pwdata[TARGET_IRQ_ENABLE_BIT];
        if (!s_q.link_enable || special_mode)
          s_d.ack_wait_limit = pwdata[3:0]; // [RQ5] [RQ6]
      end
      else if (paddr == OFS_ERROR_STATUS && pwdata[ERROR_SUMMARY_BIT])
        s_d.err_stat = 8'h00; // [RQ8] [RQ14]
      else if (paddr == OFS_REQUEST && !busy)
      begin
        s_d.pend = 1'b1;
        s_d.pend_write = pwdata[REQ_WRITE_BIT];
        s_d.pend_wdata = pwdata[15:8];
        s_d.pend_addr = pwdata[7:0];
      end
      else if (paddr == OFS_IRQ_STATUS)
        s_d.irq_stat = s_q.irq_stat & ~pwdata[2:0];
      else if (paddr == OFS_IRQ_MASK)
        s_d.irq_mask = pwdata[2:0];
    end
    // -------------------------------------------------------------
    // Error flags: hardware set wins over a software clear
    // -------------------------------------------------------------
    s_d.err_stat = s_d.err_stat | err_set;
    if (err_set[PARITY_ERROR_BIT])
      s_d.err_stat[1:0] = rx_par; // [RQ13]
    if (|err_set[ACK_WIRE_BIT:PARITY_ERROR_BIT])
      s_d.err_stat[ERROR_SUMMARY_BIT] = 1'b1; // [RQ7]
    // -------------------------------------------------------------
    // Interrupt status, mask and output
    // -------------------------------------------------------------
    if (|err_set[ACK_WIRE_BIT:PARITY_ERROR_BIT])
      s_d.irq_stat[IRQ_ERROR_BIT] = 1'b1;
    if (done)
      s_d.irq_stat[IRQ_DONE_BIT] = 1'b1;
    if (s_q.target_irq_enable && rx_irq)
      s_d.irq_stat[IRQ_TARGET_BIT] = 1'b1; // [RQ1]
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      s_q <= '{phase: ST_IDLE, ack_wait_limit: ACK_WAIT_LIMIT_RESET,
               default: '0};
    else
      s_q <= s_d;

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign link.link_clock = s_q.link_clock;
  assign link.ini_dat = s_q.dat;
  assign link.ini_dat_oe = s_q.dat_oe;
endmodule // die_link_initiator

// File: verilog/die_link_target.sv
// Target end of the die link
`timescale 1ns/10ps
module die_link_target
  import link_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  link_if.target link,
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_addr,
  output logic [7:0] req_wdata,
  input wire logic rsp_ready,
  input wire logic rsp_err,
  input wire logic [7:0] rsp_rdata,
  input wire logic irq_raise
);
  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_WDATA, T_RESP, T_RDATA, T_END
  } tphase_type;

  typedef struct packed {
    tphase_type phase;
    logic clk_prev;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic req_valid;
    logic [7:0] dat;
    logic dat_oe;
    logic ack;
    logic err;
    logic [1:0] par;
    logic irq;
  } tgt_type;

  tgt_type s_q;
  tgt_type s_d;
  logic [8:0] sync_level;
  logic rise;
  logic fall;

  pin_sync #(.WIDTH(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({link.link_clock, link.dat}),
    .level(sync_level)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.req_valid = 1'b0;
    s_d.clk_prev = sync_level[8];
    rise = sync_level[8] & ~s_q.clk_prev;
    fall = ~sync_level[8] & s_q.clk_prev;
    // -------------------------------------------------------------
    // Sample on link clock rise
    // -------------------------------------------------------------
    if (rise)
      case (s_q.phase)
        T_IDLE:
          if (sync_level[7:0] == CMD_WRITE || sync_level[7:0] == CMD_READ)
          begin
            s_d.write = (sync_level[7:0] == CMD_WRITE);
            s_d.phase = T_ADDR;
          end
        T_ADDR:
        begin
          s_d.addr = sync_level[7:0];
          s_d.phase = s_q.write ? T_WDATA : T_RESP;
          s_d.req_valid = ~s_q.write;
        end
        T_WDATA:
        begin
          s_d.wdata = sync_level[7:0];
          s_d.phase = T_RESP;
          s_d.req_valid = 1'b1;
          if (s_q.addr == IRQ_ACK_ADDR)
            s_d.irq = 1'b0; // [RQ15]
        end
        default:
          s_d.phase = s_q.phase;
      endcase
    // -------------------------------------------------------------
    // Drive on link clock fall
    // -------------------------------------------------------------
    if (fall)
      case (s_q.phase)
        T_RESP:
          if (rsp_ready)
          begin
            // Wait states last only while the user holds off ready
            s_d.ack = 1'b1; // [RQ3] [RQ4]
            s_d.dat = ACK_PATTERN;
            s_d.dat_oe = 1'b1;
            s_d.err = rsp_err;
            s_d.phase = s_q.write ? T_END : T_RDATA;
          end
        T_RDATA:
        begin
          s_d.ack = 1'b0;
          s_d.err = 1'b0;
          s_d.dat = rsp_rdata;
          s_d.par = {^rsp_rdata[7:4], ^rsp_rdata[3:0]};
          s_d.phase = T_END;
        end
        T_END:
        begin
          s_d.ack = 1'b0;
          s_d.err = 1'b0;
          s_d.dat_oe = 1'b0;
          s_d.phase = T_IDLE;
        end
        default:
          s_d.phase = s_d.phase;
      endcase
    // A raise in the clearing cycle survives
    if (irq_raise)
      s_d.irq = 1'b1; // [RQ18]
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      s_q <= '{phase: T_IDLE, default: '0};
    else
      s_q <= s_d;

  assign link.tgt_dat = s_q.dat;
  assign link.tgt_dat_oe = s_q.dat_oe;
  assign link.ack = s_q.ack;
  assign link.err = s_q.err;
  assign link.par = s_q.par;
  assign link.target_irq_pin = s_q.irq;
  assign req_valid = s_q.req_valid;
  assign req_write = s_q.write;
  assign req_addr = s_q.addr;
  assign req_wdata = s_q.wdata;
endmodule // die_link_target

// File: verilog/link_if.sv
// Die link wires between initiator and target
`timescale 1ns/10ps
interface link_if;
  logic link_clock;
  logic [7:0] ini_dat;
  logic ini_dat_oe;
  logic [7:0] tgt_dat;
  logic tgt_dat_oe;
  logic [7:0] dat;
  logic ack;
  logic err;
  logic [1:0] par;
  logic target_irq_pin;

  // Undriven data lines fall to zero through the pull-downs
  assign dat = ini_dat_oe ? ini_dat : (tgt_dat_oe ? tgt_dat : 8'h00);

  modport initiator (
    output link_clock, ini_dat, ini_dat_oe,
    input dat, ack, err, par, target_irq_pin
  );
  modport target (
    input link_clock, dat,
    output tgt_dat, tgt_dat_oe, ack, err, par, target_irq_pin
  );
endinterface

// File: verilog/link_pkg.sv
// Shared constants for the die link initiator and target ends
package link_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (APB, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_ERROR_STATUS = 8'h08;
  localparam logic [7:0] OFS_PIN_BUSY = 8'h0c;
  localparam logic [7:0] OFS_REQUEST = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LINK_ENABLE_BIT = 7;
  localparam int TARGET_IRQ_ENABLE_BIT = 7;
  localparam int ERROR_SUMMARY_BIT = 7;
  localparam int ACK_WIRE_BIT = 6;
  localparam int CANCEL_BIT = 5;
  localparam int WAIT_EXPIRED_BIT = 4;
  localparam int TARGET_ERROR_BIT = 3;
  localparam int PARITY_ERROR_BIT = 2;
  localparam int TARGET_IRQ_LEVEL_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int REQ_WRITE_BIT = 16;
  localparam int IRQ_ERROR_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_TARGET_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and link codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_WAIT_LIMIT_RESET = 4'h0;
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h81;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] ACK_PATTERN = 8'hff;
  localparam logic [7:0] IRQ_ACK_ADDR = 8'hff;

  // ----------------------------------------------------------------
  // Timing: pclk cycles per half period of the link clock
  // ----------------------------------------------------------------
  localparam int LINK_HALF_PERIOD = 16;

endpackage

// File: verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_type;

  sync_type s_q;
  sync_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // Only stages two and three are compared; stage one stays private
    for (int i = 0; i < WIDTH; i++)
      if (s_q.s2[i] == s_q.s3[i])
        s_d.level[i] = s_q.s3[i];
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;

  assign level = s_q.level;
endmodule // pin_sync
